// *** rtl/serial_link_defines.svh ***
// constants of the serial setup block: field positions, reset values, timing
`ifndef SERIAL_LINK_DEFINES_SVH
`define SERIAL_LINK_DEFINES_SVH
`define CLK_HZ             100_000_000
`define BAUD_MAX           38400
`define BIT_CYC_MAX        (`CLK_HZ / `BAUD_MAX)
`define FMT_LF_BIT         7
`define FMT_PODD_BIT       6
`define FMT_PEN_BIT        5
`define FMT_BAUD_MSB       2
`define FMT_RST            8'h07
`define OPT_ECHO_BIT       2
`define OPT_DLY_MSB        1
`define OPT_RST            8'h01
`define BAUD_DFLT          3'h7
`define CH_CR              7'h0D
`define CH_LF              7'h0A
`define FRAME_BITS         10
`define DLY_UNITS_PER_STEP 2
`define SU_NCHARS          4'h8
`define RSP_FIFO_DEPTH     32
`define RSP_FIFO_WIDTH     8
`endif

// *** rtl/serial_link_pkg.sv ***
// types shared by the serial setup block
package serial_link_pkg;
  typedef logic [6:0] char_t;
  typedef enum logic [6:0] {
    T_IDLE    = 7'b000_0001,
    T_DELAY   = 7'b000_0010,
    T_LF_PRE  = 7'b000_0100,
    T_BODY    = 7'b000_1000,
    T_CR      = 7'b001_0000,
    T_LF_POST = 7'b010_0000,
    T_DONE    = 7'b100_0000
  } tx_state_t;
endpackage : serial_link_pkg

// *** rtl/rsp_fifo.sv ***
// response fifo with registered read data and honest full/empty
`timescale 1ns/10ps
module rsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock, reset, enable
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready_ff,
  // drain side
  output logic                  out_valid_ff,
  output logic [WIDTH-1:0]      out_data_ff,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff, rd_ptr_ff;
  logic [AW:0]      count_ff, nxt_count;
  logic             push, fill;

  // fill the output register whenever it is empty or being taken
  assign push = ce & in_valid & in_ready_ff;
  assign fill = ce & (~out_valid_ff | out_ready) & (count_ff != '0);
  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(fill);

  // storage array has no reset; pointers, level, ready and output register do
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers, level and ready
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      count_ff    <= '0;
      in_ready_ff <= 1'b1;
    end else if (ce) begin
      if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (fill) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      count_ff    <= nxt_count;
      in_ready_ff <= (nxt_count < (AW+1)'(DEPTH));
    end
  end

  // output register stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (ce) begin
      if (fill) begin
        out_valid_ff <= 1'b1;
        out_data_ff  <= mem_ff[rd_ptr_ff];
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end
endmodule : rsp_fifo

// *** rtl/serial_rx.sv ***
// receiver for one 10-bit frame: start, 7 data, parity, stop
`timescale 1ns/10ps
module serial_rx (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // synchronised line and bit period in cycles
  input  wire logic        rxd_s,
  input  wire logic [19:0] bit_div,
  // received character
  output logic             valid_ff,
  output logic [6:0]       data_ff,
  output logic             pbit_ff
);
  logic        busy_ff;
  logic [19:0] cnt_ff;
  logic [3:0]  idx_ff;
  logic [7:0]  sh_ff;

  // start detect, mid-bit sampling, stop check
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= '0;
      idx_ff   <= '0;
      sh_ff    <= '0;
      valid_ff <= 1'b0;
      data_ff  <= '0;
      pbit_ff  <= 1'b0;
    end else if (ce) begin
      valid_ff <= 1'b0;
      if (!busy_ff) begin
        if (!rxd_s) begin
          busy_ff <= 1'b1;
          cnt_ff  <= bit_div >> 1;
          idx_ff  <= '0;
        end
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 20'h0_0001;
      end else begin
        cnt_ff <= bit_div - 20'h0_0001;
        if (idx_ff == 4'h0) begin
          // a glitch shorter than half a bit is not a start
          busy_ff <= ~rxd_s;
          idx_ff  <= 4'h1;
        end else if (idx_ff < 4'h9) begin
          sh_ff  <= {rxd_s, sh_ff[7:1]};
          idx_ff <= idx_ff + 4'h1;
        end else begin
          busy_ff  <= 1'b0;
          valid_ff <= rxd_s;  // framing errors drop the character
          data_ff  <= sh_ff[6:0];
          pbit_ff  <= sh_ff[7];
        end
      end
    end
  end
endmodule : serial_rx

// *** rtl/serial_link_setup_options.sv ***
// serial channel with setup-driven framing, parity, baud, echo and delay
// Notes on behaviour
// - setup bit 7 adds linefeed before and after
// - every response body is followed by carriage return
// - added linefeeds stay out of checksum
// - parity off: ignore rx parity, send zero except on echoes
// - parity on: check and generate, bit6 odd
// - rx parity error flags the command
// - new parity starts after its acknowledgement
// - baud code halves rate from 38400 down
// - baud changes only after reset or remote reset
// - readback shows stored baud code at once
// - default mode forces 300 baud
// - options byte resets to 01
// - echo bit retransmits received characters; a newer one replaces an echo not yet sent
// - delay code adds 0, 2, 4, 6 units
// - one unit is one character time
// - delay adds to processing latency
// - answer after carriage return, drop linefeed
// - setup write needs exactly eight characters
`include "serial_link_defines.svh"
`timescale 1ns/10ps
module serial_link_setup_options #(
  parameter int unsigned BASE_DIV   = `BIT_CYC_MAX,
  parameter int unsigned FIFO_DEPTH = `RSP_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // serial line and default mode strap
  input  wire logic                   rxd,
  output logic                        txd_ff,
  input  wire logic                   dflt_mode,
  // received characters toward the command parser
  output logic                        rx_valid_ff,
  output serial_link_pkg::char_t      rx_data_ff,
  output logic                        cmd_end_ff,
  output logic                        cmd_perr_ff,
  // response body from the command parser
  input  wire logic                   rsp_valid,
  input  wire serial_link_pkg::char_t rsp_data,
  input  wire logic                   rsp_last,
  output logic                        rsp_ready,
  output logic                        rsp_done_ff,
  // setup access
  input  wire logic                   su_wr,
  input  wire logic [3:0]             su_nchars,
  input  wire logic [7:0]             su_fmt,
  input  wire logic [7:0]             su_opt,
  input  wire logic                   rr_req,
  output logic [7:0]                  fmt_ff,
  output logic [7:0]                  opt_ff,
  output logic                        su_err_ff,
  output logic [2:0]                  baud_act_ff
);
  import serial_link_pkg::*;

  localparam logic [7:0] FMT_RST_L  = `FMT_RST;
  localparam logic [6:0] DLY_STEP   = 7'(`DLY_UNITS_PER_STEP * `FRAME_BITS);
  localparam logic [3:0] FRAME_BITS = 4'(`FRAME_BITS);

  tx_state_t   st_ff;
  logic        rxd_meta_ff, rxd_sync_ff, dflt_meta_ff, dflt_sync_ff;
  logic [2:0]  eff_baud;
  logic [19:0] bit_div, tick_cnt_ff;
  logic        tick_ff;
  logic        rxc_valid, rxc_pbit, rxc_perr, rxc_cr, rxc_lf;
  char_t       rxc_data;
  logic        perr_acc_ff, lf_skip_ff;
  logic        pen_act_ff, podd_act_ff, par_pend_ff, rr_pend_ff;
  logic        su_ok;
  logic        echo_pend_ff, echo_par_ff;
  char_t       echo_ch_ff;
  logic [7:0]  fifo_q;
  logic        fifo_qv, fifo_rd;
  logic [6:0]  dly_ff, dly_load;
  logic        tx_load, tx_pbit, tx_busy_ff;
  char_t       tx_char;
  logic [9:0]  tx_sh_ff;
  logic [3:0]  tx_cnt_ff;
  logic        done_now;

  // line and strap pass two flops before any logic looks at them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxd_meta_ff  <= 1'b1;
      rxd_sync_ff  <= 1'b1;
      dflt_meta_ff <= 1'b0;
      dflt_sync_ff <= 1'b0;
    end else if (ce) begin
      rxd_meta_ff  <= rxd;
      rxd_sync_ff  <= rxd_meta_ff;
      dflt_meta_ff <= dflt_mode;
      dflt_sync_ff <= dflt_meta_ff;
    end
  end

  // bit period: base divisor doubled per code step, fixed slowest in default mode
  assign eff_baud = dflt_sync_ff ? `BAUD_DFLT : baud_act_ff;
  assign bit_div  = 20'(BASE_DIV) << eff_baud;

  // free-running bit tick shared by transmitter and delay counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (ce) begin
      if (tick_cnt_ff >= bit_div - 20'h0_0001) begin
        tick_cnt_ff <= '0;
        tick_ff     <= 1'b1;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 20'h0_0001;
        tick_ff     <= 1'b0;
      end
    end
  end

  serial_rx u_rx (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .rxd_s    (rxd_sync_ff),
    .bit_div  (bit_div),
    .valid_ff (rxc_valid),
    .data_ff  (rxc_data),
    .pbit_ff  (rxc_pbit)
  );

  // parity is only judged while it is switched on
  assign rxc_perr = pen_act_ff & (^{rxc_data, rxc_pbit} ^ podd_act_ff);
  assign rxc_cr   = (rxc_data == `CH_CR);
  assign rxc_lf   = (rxc_data == `CH_LF);

  // command stream toward the parser, closed by carriage return
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
      cmd_end_ff  <= 1'b0;
      cmd_perr_ff <= 1'b0;
      perr_acc_ff <= 1'b0;
      lf_skip_ff  <= 1'b0;
    end else if (ce) begin
      rx_valid_ff <= 1'b0;
      cmd_end_ff  <= 1'b0;
      if (rxc_valid) begin
        if (rxc_cr) begin
          cmd_end_ff  <= 1'b1;
          cmd_perr_ff <= perr_acc_ff | rxc_perr;
          perr_acc_ff <= 1'b0;
          lf_skip_ff  <= 1'b1;
        end else if (rxc_lf && lf_skip_ff) begin
          lf_skip_ff  <= 1'b0;
        end else begin
          rx_valid_ff <= 1'b1;
          rx_data_ff  <= rxc_data;
          perr_acc_ff <= perr_acc_ff | rxc_perr;
          lf_skip_ff  <= 1'b0;
        end
      end
    end
  end

  // setup store: whole write accepted only with exactly eight characters
  assign su_ok = ce & su_wr & (su_nchars == `SU_NCHARS);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fmt_ff    <= `FMT_RST;
      opt_ff    <= `OPT_RST;
      su_err_ff <= 1'b0;
    end else if (ce) begin
      su_err_ff <= su_wr & (su_nchars != `SU_NCHARS);
      if (su_ok) begin
        fmt_ff <= su_fmt;
        opt_ff <= su_opt;
      end
    end
  end

  // the end of a response is where staged parity and baud take over
  assign done_now = ce & (st_ff == T_DONE) & ~tx_busy_ff;

  // active parity and baud; a new request wins over a same-cycle apply
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pen_act_ff  <= FMT_RST_L[`FMT_PEN_BIT];
      podd_act_ff <= FMT_RST_L[`FMT_PODD_BIT];
      baud_act_ff <= FMT_RST_L[`FMT_BAUD_MSB:0];
      par_pend_ff <= 1'b0;
      rr_pend_ff  <= 1'b0;
    end else if (ce) begin
      if (su_ok) begin
        par_pend_ff <= 1'b1;
      end else if (done_now && par_pend_ff) begin
        pen_act_ff  <= fmt_ff[`FMT_PEN_BIT];
        podd_act_ff <= fmt_ff[`FMT_PODD_BIT];
        par_pend_ff <= 1'b0;
      end
      if (rr_req) begin
        rr_pend_ff <= 1'b1;
      end else if (done_now && rr_pend_ff) begin
        baud_act_ff <= fmt_ff[`FMT_BAUD_MSB:0];
        rr_pend_ff  <= 1'b0;
      end
    end
  end

  // echo keeps the received parity bit so the chain sees the frame unchanged
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      echo_pend_ff <= 1'b0;
      echo_ch_ff   <= '0;
      echo_par_ff  <= 1'b0;
    end else if (ce) begin
      if (rxc_valid && opt_ff[`OPT_ECHO_BIT]) begin
        echo_pend_ff <= 1'b1;
        echo_ch_ff   <= rxc_data;
        echo_par_ff  <= rxc_pbit;
      end else if (tx_load && st_ff == T_IDLE) begin
        echo_pend_ff <= 1'b0;
      end
    end
  end

  rsp_fifo #(
    .WIDTH (`RSP_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .ce           (ce),
    .in_valid     (rsp_valid),
    .in_data      ({rsp_last, rsp_data}),
    .in_ready_ff  (rsp_ready),
    .out_valid_ff (fifo_qv),
    .out_data_ff  (fifo_q),
    .out_ready    (fifo_rd)
  );

  // character picker: linefeeds come from here, never from the body stream,
  // so a checksum built by the parser over the body cannot include them
  always_comb begin
    tx_load = 1'b0;
    tx_char = '0;
    fifo_rd = 1'b0;
    if (ce && !tx_busy_ff) begin
      case (st_ff)
        T_IDLE: begin
          if (echo_pend_ff) begin
            tx_load = 1'b1;
            tx_char = echo_ch_ff;
          end
        end
        T_LF_PRE, T_LF_POST: begin
          tx_load = 1'b1;
          tx_char = `CH_LF;
        end
        T_BODY: begin
          if (fifo_qv) begin
            tx_load = 1'b1;
            tx_char = fifo_q[6:0];
            fifo_rd = 1'b1;
          end
        end
        T_CR: begin
          tx_load = 1'b1;
          tx_char = `CH_CR;
        end
        default: begin
          tx_load = 1'b0;
        end
      endcase
    end
  end

  // outgoing parity: echoes keep the received bit; otherwise zero when off, even or odd by setup when on
  assign tx_pbit = (st_ff == T_IDLE) ? echo_par_ff :
                   (pen_act_ff & (^tx_char ^ podd_act_ff));

  // delay in bit ticks: two character times per code step, ten bits each
  assign dly_load = 7'(opt_ff[`OPT_DLY_MSB:0]) * DLY_STEP;

  // response sequencer; the delay starts once the parser has a response,
  // so it comes on top of the parser's own latency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff       <= T_IDLE;
      dly_ff      <= '0;
      rsp_done_ff <= 1'b0;
    end else if (ce) begin
      rsp_done_ff <= 1'b0;
      case (st_ff)
        T_IDLE: begin
          if (fifo_qv && !echo_pend_ff && !tx_busy_ff) begin
            dly_ff <= dly_load;
            if (dly_load != '0) st_ff <= T_DELAY;
            else st_ff <= fmt_ff[`FMT_LF_BIT] ? T_LF_PRE : T_BODY;
          end
        end
        T_DELAY: begin
          if (tick_ff) begin
            if (dly_ff == '0) st_ff <= fmt_ff[`FMT_LF_BIT] ? T_LF_PRE : T_BODY;
            else dly_ff <= dly_ff - 7'h01;
          end
        end
        T_LF_PRE: begin
          if (tx_load) st_ff <= T_BODY;
        end
        T_BODY: begin
          if (tx_load && fifo_q[7]) st_ff <= T_CR;
        end
        T_CR: begin
          if (tx_load) st_ff <= fmt_ff[`FMT_LF_BIT] ? T_LF_POST : T_DONE;
        end
        T_LF_POST: begin
          if (tx_load) st_ff <= T_DONE;
        end
        T_DONE: begin
          if (!tx_busy_ff) begin
            st_ff       <= T_IDLE;
            rsp_done_ff <= 1'b1;
          end
        end
        default: begin
          st_ff <= T_IDLE;
        end
      endcase
    end
  end

  // transmit shifter: start, 7 data, parity, stop, one bit per tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txd_ff     <= 1'b1;
      tx_sh_ff   <= '1;
      tx_cnt_ff  <= '0;
      tx_busy_ff <= 1'b0;
    end else if (ce) begin
      if (tx_load) begin
        tx_sh_ff   <= {1'b1, tx_pbit, tx_char, 1'b0};
        tx_cnt_ff  <= FRAME_BITS;
        tx_busy_ff <= 1'b1;
      end else if (tick_ff && tx_busy_ff) begin
        txd_ff    <= tx_sh_ff[0];
        tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
        tx_cnt_ff <= tx_cnt_ff - 4'h1;
        // busy drops as the stop bit starts; next start waits a full tick
        if (tx_cnt_ff == 4'h1) tx_busy_ff <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_cr_after_last: assert property (st_ff == T_BODY && tx_load && fifo_q[7] |=> st_ff == T_CR)
    else $error("last body character not followed by carriage return");
  a_lf_framing: assert property (st_ff == T_CR && tx_load |=>
    st_ff == ($past(fmt_ff[`FMT_LF_BIT]) ? T_LF_POST : T_DONE))
    else $error("trailing linefeed does not follow setup bit");
  a_par_zero: assert property (tx_load && st_ff != T_IDLE && !pen_act_ff |-> !tx_pbit)
    else $error("parity bit not zero with parity off");
  a_par_gen: assert property (tx_load && st_ff != T_IDLE && pen_act_ff |=>
    tx_sh_ff[8] == (^$past(tx_char) ^ $past(podd_act_ff)))
    else $error("wrong parity on sent character");
  a_par_switch: assert property ($changed(pen_act_ff) || $changed(podd_act_ff) |->
    $past(st_ff) == T_DONE && !$past(tx_busy_ff))
    else $error("parity switched before acknowledgement ended");
  a_baud_hold: assert property ($changed(baud_act_ff) |-> $past(rr_pend_ff) && $past(st_ff) == T_DONE)
    else $error("baud changed without reset");
  a_dflt_baud: assert property (dflt_sync_ff |-> bit_div == (20'(BASE_DIV) << `BAUD_DFLT))
    else $error("default mode not at slowest rate");
  a_su_reject: assert property (ce && su_wr && su_nchars != `SU_NCHARS |=> $stable(fmt_ff) && su_err_ff)
    else $error("bad setup write not rejected");
  a_echo_taken: assert property (ce && rxc_valid && opt_ff[`OPT_ECHO_BIT] |=> echo_pend_ff && echo_ch_ff == $past(rxc_data))
    else $error("received character not queued for echo");
  a_perr_report: assert property (ce && rxc_valid && rxc_cr && rxc_perr |=> cmd_end_ff && cmd_perr_ff)
    else $error("parity error not reported at command end");

  c_lf_response: cover property (st_ff == T_LF_POST && tx_load);
  c_delayed_rsp: cover property (st_ff == T_DELAY ##1 st_ff != T_DELAY);
  c_parity_err:  cover property (cmd_end_ff && cmd_perr_ff);
  c_baud_switch: cover property ($changed(baud_act_ff));
endmodule : serial_link_setup_options

// *** tb/host_term.sv ***
// host terminal model: sends command frames and collects the frames the block transmits
`timescale 1ns/10ps
module host_term (
  // clock
  input  wire logic clk_sys,
  // serial line
  input  wire logic txd,
  output logic      rxd
);
  int         bit_cyc = 1024;
  time        t_first;
  logic [8:0] got[$];
  logic [8:0] fr;

  // idle line is high between frames
  initial rxd = 1'b1;

  // frame receiver: samples mid bit, keeps {stop, parity, data}
  always begin
    @(negedge txd);
    if (got.size() == 0) t_first = $time;
    repeat (bit_cyc / 2) @(posedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge clk_sys);
      fr[i] = txd;
    end
    got.push_back(fr);
  end

  // one frame out; parity bit is given so a scenario can corrupt it
  task automatic send(input logic [6:0] c, input logic p);
    logic [9:0] f;
    f = {1'b1, p, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      rxd = f[i];
      repeat (bit_cyc - 1) @(negedge clk_sys);
    end
  endtask : send
endmodule : host_term

// *** tb/test_serial_link_setup_options.sv ***
// testbench of the serial setup block: setup access, framing, parity, baud, delay, echo
`include "serial_link_defines.svh"
`timescale 1ns/10ps
module test_serial_link_setup_options;
  import serial_link_pkg::*;
  logic       clk_sys, rst, ce, rxd, txd_ff, dflt_mode;
  logic       rx_valid_ff, cmd_end_ff, cmd_perr_ff;
  char_t      rx_data_ff, rsp_data;
  logic       rsp_valid, rsp_last, rsp_ready, rsp_done_ff;
  logic       su_wr, rr_req, su_err_ff;
  logic [3:0] su_nchars;
  logic [7:0] su_fmt, su_opt, fmt_ff, opt_ff, prev;
  logic [2:0] baud_act_ff;
  int         n_mismatch, n_tests, n_stall, k;
  time        t_acc, lat;
  char_t      rxq[$];
  logic       endq[$];
  logic [7:0] tbl[3] = '{8'hA0, 8'hE0, 8'h20};

  serial_link_setup_options #(.BASE_DIV(8), .FIFO_DEPTH(32)) uut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .rxd(rxd), .txd_ff(txd_ff), .dflt_mode(dflt_mode),
    .rx_valid_ff(rx_valid_ff), .rx_data_ff(rx_data_ff), .cmd_end_ff(cmd_end_ff), .cmd_perr_ff(cmd_perr_ff),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .rsp_done_ff(rsp_done_ff), .su_wr(su_wr), .su_nchars(su_nchars), .su_fmt(su_fmt), .su_opt(su_opt),
    .rr_req(rr_req), .fmt_ff(fmt_ff), .opt_ff(opt_ff), .su_err_ff(su_err_ff), .baud_act_ff(baud_act_ff));

  host_term host (.clk_sys(clk_sys), .txd(txd_ff), .rxd(rxd));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // collect what reaches the parser side, count refused offers
  always @(negedge clk_sys) begin
    if (rx_valid_ff === 1'b1) rxq.push_back(rx_data_ff);
    if (cmd_end_ff === 1'b1) endq.push_back(cmd_perr_ff);
    if (rsp_valid === 1'b1 && rsp_ready === 1'b0) n_stall++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // a bound ran out: count it and stop
  task automatic tmo();
    n_mismatch++;
    end_sim();
  endtask : tmo

  function automatic logic par(input char_t c, input logic [7:0] f);
    return f[`FMT_PEN_BIT] & (^c ^ f[`FMT_PODD_BIT]);
  endfunction : par

  // setup write; bits 3 and 4 always written as zero
  task automatic su(input logic [7:0] f, input logic [7:0] o, input logic [3:0] n);
    su_wr     = 1'b1;
    su_fmt    = f;
    su_opt    = o;
    su_nchars = n;
    @(negedge clk_sys);
    su_wr = 1'b0;
    chk(su_err_ff, n != 4'h8);
    if (n == 4'h8) begin
      chk(fmt_ff, f);
      chk(opt_ff, o);
    end
    // one idle cycle so back-to-back writes stay separate pulses
    @(negedge clk_sys);
  endtask : su

  // offer a response body, holding valid until each char is taken
  task automatic send_rsp(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rsp_valid = 1'b1;
      rsp_data  = char_t'(s[i]);
      rsp_last  = (i == s.len() - 1);
      for (k = 0; k < 4000 && rsp_ready !== 1'b1; k++) @(negedge clk_sys);
      if (k == 4000) tmo();
      t_acc = $time + 5;
      @(negedge clk_sys);
    end
    rsp_valid = 1'b0;
    rsp_last  = 1'b0;
  endtask : send_rsp

  task automatic wait_done(input int lim);
    for (k = 0; k < lim && rsp_done_ff !== 1'b1; k++) @(negedge clk_sys);
    if (k == lim) tmo();
    // done comes as the last stop bit starts; let the host sample it
    repeat (host.bit_cyc) @(negedge clk_sys);
  endtask : wait_done

  // frames expected for a body under format byte f
  task automatic chk_rsp(input string s, input logic [7:0] f);
    logic [8:0] e[$];
    if (f[7]) e.push_back({1'b1, par(`CH_LF, f), `CH_LF});
    for (int i = 0; i < s.len(); i++) e.push_back({1'b1, par(char_t'(s[i]), f), char_t'(s[i])});
    e.push_back({1'b1, par(`CH_CR, f), `CH_CR});
    if (f[7]) e.push_back({1'b1, par(`CH_LF, f), `CH_LF});
    chk(host.got.size(), e.size());
    foreach (e[i]) chk(host.got[i], e[i]);
    host.got.delete();
  endtask : chk_rsp

  // host command "A" CR LF with chosen parity bits
  task automatic rx_cmd(input logic pa, input logic pc, input logic ep);
    host.send(7'h41, pa);
    host.send(`CH_CR, pc);
    host.send(`CH_LF, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk(rxq.size(), 1);
    chk(rxq.pop_front(), 7'h41);
    chk(endq.size(), 1);
    chk(endq.pop_front(), ep);
    rxq.delete();
    endq.delete();
  endtask : rx_cmd

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    dflt_mode = 1'b0;
    rsp_valid = 1'b0;
    rsp_last = 1'b0;
    rsp_data = 7'h00;
    su_wr = 1'b0;
    rr_req = 1'b0;
    su_nchars = 4'h0;
    su_fmt = 8'h00;
    su_opt = 8'h00;
    prev = 8'h00;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(fmt_ff, 8'h07);
    chk(opt_ff, 8'h01);
    chk(baud_act_ff, 3'h7);
    su(8'hE7, 8'h03, 4'h7);
    chk(fmt_ff, 8'h07);
    // a good write while the enable is low must not land
    ce        = 1'b0;
    su_wr     = 1'b1;
    su_nchars = 4'h8;
    @(negedge clk_sys);
    su_wr = 1'b0;
    ce    = 1'b1;
    chk(fmt_ff, 8'h07);
    @(negedge clk_sys);
    $display("test reset and refused write done");
    // new rate is stored but not used until a remote reset and its answer
    su(8'h00, 8'h00, 4'h8);
    chk(baud_act_ff, 3'h7);
    rr_req = 1'b1;
    @(negedge clk_sys);
    rr_req = 1'b0;
    send_rsp("*");
    wait_done(30000);
    chk_rsp("*", 8'h00);
    repeat (2) @(negedge clk_sys);
    chk(baud_act_ff, 3'h0);
    host.bit_cyc = 8;
    $display("test baud change done");
    rx_cmd(1'b1, 1'b0, 1'b0);
    send_rsp("0123456789ABCDEFGHIJ0123456789ABCDEFGHIJ");
    wait_done(8000);
    chk(n_stall > 0, 1'b1);
    chk_rsp("0123456789ABCDEFGHIJ0123456789ABCDEFGHIJ", 8'h00);
    $display("test fill and drain done");
    // acknowledgement keeps the old parity, the next answer takes the new one
    foreach (tbl[i]) begin
      su(tbl[i], 8'h00, 4'h8);
      send_rsp("*");
      wait_done(3000);
      chk_rsp("*", {tbl[i][7], prev[6:0]});
      send_rsp("C");
      wait_done(3000);
      chk_rsp("C", tbl[i]);
      prev = tbl[i];
    end
    rx_cmd(1'b0, 1'b1, 1'b0);
    rx_cmd(1'b1, 1'b1, 1'b1);
    $display("test parity and linefeed done");
    // each delay unit is ten bit times at 8 cycles a bit
    for (int c = 0; c < 4; c++) begin
      su(8'h20, 8'(c), 4'h8);
      send_rsp("*");
      wait_done(3000);
      lat = (host.t_first - t_acc) / 10;
      chk(lat >= c * 160 && lat <= c * 160 + 24, 1'b1);
      chk_rsp("*", 8'h20);
    end
    $display("test delay done");
    su(8'h20, 8'h04, 4'h8);
    host.send(7'h42, 1'b0);
    host.send(`CH_CR, 1'b1);
    for (k = 0; k < 2000 && host.got.size() < 2; k++) @(negedge clk_sys);
    if (k == 2000) tmo();
    chk(host.got[0], {2'b10, 7'h42});
    chk(host.got[1], {2'b11, `CH_CR});
    $display("test echo done");
    // default mode strap forces the slowest rate whatever code is active
    host.got.delete();
    dflt_mode = 1'b1;
    repeat (3) @(negedge clk_sys);
    host.bit_cyc = 1024;
    send_rsp("*");
    wait_done(30000);
    chk_rsp("*", 8'h20);
    chk(baud_act_ff, 3'h0);
    $display("test default mode done");
    end_sim();
  end
endmodule : test_serial_link_setup_options
